// >>> hdl/ddrb2_params.svh
`ifndef DDRB2_PARAMS_SVH
`define DDRB2_PARAMS_SVH

// Lane width covered by one byte-write select.
`define DDRB2_LANE_W 9
// Narrow variant: 18-bit data, two lanes, 20-bit address.
`define DDRB2_DATA_W 18
`define DDRB2_LANES 2
`define DDRB2_ADDR_W 20
// Extra K cycles between fetch and first read beat.
`define DDRB2_RD_LAT 1
// Reset values of the control flops.
`define DDRB2_RST_BIT 1'h0
`define DDRB2_RST_PHASE 1'h0

`endif

// >>> hdl/ddrb2_pkg.sv
`include "ddrb2_params.svh"

package ddrb2_pkg;

  // Operation captured at the positive input clock edge.
  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_WRITE = 2'b01,
    OP_READ = 2'b10
  } ddrb2_op_type;

  // Loaded address: row index plus the burst start bit.
  typedef struct packed {
    logic [`DDRB2_ADDR_W-2:0] row;
    logic lsb;
  } ddrb2_req_type;

  // One write beat with its lane mask, active low.
  typedef struct packed {
    logic [`DDRB2_DATA_W-1:0] data;
    logic [`DDRB2_LANES-1:0] byte_write_sel_n;
  } ddrb2_beat_type;

  // The two words of one read burst, in output order.
  typedef struct packed {
    logic [`DDRB2_DATA_W-1:0] w1;
    logic [`DDRB2_DATA_W-1:0] w0;
  } ddrb2_pair_type;

endpackage

// >>> hdl/ddrb2_sync.sv
`timescale 1ns/1ns
`default_nettype none

module ddrb2_sync (
  // Destination clock.
  input wire logic i_clk,
  // Level from another domain.
  input wire logic i_d,
  output logic o_q
);

  logic meta_ff;
  logic hold_ff;

  // Two-stage resynchroniser; only the second stage is read.
  always_ff @(posedge i_clk) begin
    meta_ff <= i_d;
    hold_ff <= meta_ff;
  end

  assign o_q = hold_ff;

endmodule

`default_nettype wire

// >>> hdl/ddrb2_launch.sv
`timescale 1ns/1ns
`default_nettype none
`include "ddrb2_params.svh"

module ddrb2_launch (
  // Launch clock pair, rising and falling edge.
  input wire logic i_clk,
  input wire logic i_nrst,
  // Burst to send.
  input wire logic i_start,
  input wire ddrb2_pkg::ddrb2_pair_type i_pair,
  // Output drivers.
  output logic [`DDRB2_DATA_W-1:0] o_data,
  output logic o_oe
);

  ddrb2_pkg::ddrb2_pair_type pair_ff;
  logic act_ff;
  logic pos_ph_ff;
  logic neg_ph_ff;

  // Rising edge loads the burst and opens the drivers for one cycle.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      act_ff <= `DDRB2_RST_BIT;
      pos_ph_ff <= `DDRB2_RST_PHASE;
    end else begin
      act_ff <= i_start;
      pos_ph_ff <= ~pos_ph_ff;
    end
  end

  // Burst words are held until the next start.
  always_ff @(posedge i_clk) begin
    if (i_start) begin
      pair_ff <= i_pair;
    end
  end

  // Falling edge (complementary rising) catches up the phase.
  always_ff @(negedge i_clk) begin
    if (!i_nrst) begin
      neg_ph_ff <= `DDRB2_RST_PHASE;
    end else begin
      neg_ph_ff <= pos_ph_ff;
    end
  end

  // First word after the rising edge, second after the falling one.
  assign o_data = (pos_ph_ff == neg_ph_ff) ? pair_ff.w1 : pair_ff.w0;
  assign o_oe = act_ff;

endmodule

`default_nettype wire

// >>> hdl/ddrb2_port.sv
// What this block does
// - Write data captured on both input clock edges.
// - Read words driven on both output clock edges.
// - Single-clock mode launches reads on input clocks.
// - Data drivers tristate when no read active.
// - Every transaction moves exactly two words.
// - Byte selects active low, sampled both edges.
// - Each byte select aligned with its beat.
// - Unselected bytes are dropped, memory kept.
// - Each select governs one nine-bit lane.
// - Data bus 18 bits wide.
// - Same address pins serve reads and writes.
// - Storage is two equal word arrays.
// - Burst bit seeds counter, second word follows.
// - Address ignored while port is deselected.
// - Accesses start on positive input clock edge.
// - Free-running echo clocks follow launch clock.
`timescale 1ns/1ns
`default_nettype none
`include "ddrb2_params.svh"

module ddrb2_port #(
  parameter int ARRAY_AW = `DDRB2_ADDR_W - 1,
  parameter int RD_LAT = `DDRB2_RD_LAT
) (
  // Input clock pair (falling edge is the complementary clock).
  input wire logic i_clock,
  input wire logic i_nrst,
  // Output data clock pair and single-clock strap.
  input wire logic i_out_clock,
  input wire logic i_single_clk_mode,
  // Controller command pins.
  input wire logic i_load_strobe_n,
  input wire logic i_rnw,
  input wire logic [`DDRB2_ADDR_W-2:0] i_addr,
  input wire logic i_burst_lsb_addr,
  input wire logic [`DDRB2_LANES-1:0] i_byte_write_sel_n,
  // Shared data bus as input, output and enable.
  input wire logic [`DDRB2_DATA_W-1:0] i_dq_i,
  output logic [`DDRB2_DATA_W-1:0] o_dq_o,
  output logic o_dq_oe,
  // Echo clocks.
  output logic o_echo_clk,
  output logic o_echo_clk_n
);

  localparam int DW = `DDRB2_DATA_W;
  localparam int LW = `DDRB2_LANE_W;
  localparam int NL = `DDRB2_LANES;
  localparam int DEPTH = 1 << ARRAY_AW;
  localparam int LAUNCH_DLY = RD_LAT + 1;

  ddrb2_pkg::ddrb2_op_type state_ff;
  ddrb2_pkg::ddrb2_req_type req_ff;
  ddrb2_pkg::ddrb2_beat_type beat0_ff;
  ddrb2_pkg::ddrb2_beat_type beat1_ff;
  ddrb2_pkg::ddrb2_pair_type fetch;
  ddrb2_pkg::ddrb2_pair_type pipe_ff [0:RD_LAT-1];
  ddrb2_pkg::ddrb2_pair_type xfer_ff;
  logic lat_ff [0:RD_LAT-1];
  logic [DW-1:0] arr0_ff [0:DEPTH-1];
  logic [DW-1:0] arr1_ff [0:DEPTH-1];
  logic [ARRAY_AW-1:0] row;
  logic cmd_sel;
  logic mode_k;
  logic start_k;
  logic rd_tgl_ff;
  logic k_oe;
  logic [DW-1:0] k_data;
  logic nrst_c;
  logic tgl_c;
  logic tgl_d_ff;
  logic start_c;
  logic c_oe;
  logic [DW-1:0] c_data;

  // Merges a beat into a stored word lane by lane.
  function automatic logic [DW-1:0] lane_merge(
    input logic [DW-1:0] old,
    input ddrb2_pkg::ddrb2_beat_type b
  );
    logic [DW-1:0] res;
    res = old;
    for (int l = 0; l < NL; l++) begin
      if (!b.byte_write_sel_n[l]) begin
        res[l*LW +: LW] = b.data[l*LW +: LW];
      end
    end
    return res;
  endfunction

  // A cycle is selected only while the load strobe is low.
  assign cmd_sel = !i_load_strobe_n;
  assign row = req_ff.row[ARRAY_AW-1:0];

  // The strap is a pin and is resynchronised before use.
  ddrb2_sync u_mode_sync (
    .i_clk(i_clock),
    .i_d(i_single_clk_mode),
    .o_q(mode_k)
  );

  // Operation decode on the positive input clock edge.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      state_ff <= ddrb2_pkg::OP_IDLE;
    end else if (cmd_sel) begin
      state_ff <= i_rnw ? ddrb2_pkg::OP_READ
                        : ddrb2_pkg::OP_WRITE;
    end else begin
      state_ff <= ddrb2_pkg::OP_IDLE;
    end
  end

  // One shared address port; held while deselected.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      req_ff <= '0;
    end else if (cmd_sel) begin
      req_ff.row <= i_addr;
      req_ff.lsb <= i_burst_lsb_addr;
    end
  end

  // First write beat and mask come with the rising edge of the load.
  always_ff @(posedge i_clock) begin
    if (cmd_sel && !i_rnw) begin
      beat0_ff.data <= i_dq_i;
      beat0_ff.byte_write_sel_n <= i_byte_write_sel_n;
    end
  end

  // Second beat and mask come with the complementary clock edge.
  always_ff @(negedge i_clock) begin
    if (state_ff == ddrb2_pkg::OP_WRITE) begin
      beat1_ff.data <= i_dq_i;
      beat1_ff.byte_write_sel_n <= i_byte_write_sel_n;
    end
  end

  // Commit both beats: first at the seed, second at the seed plus one.
  always_ff @(posedge i_clock) begin
    if (state_ff == ddrb2_pkg::OP_WRITE) begin
      if (!req_ff.lsb) begin
        arr0_ff[row] <= lane_merge(arr0_ff[row], beat0_ff);
        arr1_ff[row] <= lane_merge(arr1_ff[row], beat1_ff);
      end else begin
        arr1_ff[row] <= lane_merge(arr1_ff[row], beat0_ff);
        arr0_ff[row] <= lane_merge(arr0_ff[row], beat1_ff);
      end
    end
  end

  // Read fetch orders the pair by the burst start bit.
  always_comb begin
    if (req_ff.lsb) begin
      fetch.w0 = arr1_ff[row];
      fetch.w1 = arr0_ff[row];
    end else begin
      fetch.w0 = arr0_ff[row];
      fetch.w1 = arr1_ff[row];
    end
  end

  // First latency stage takes the read flag.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      lat_ff[0] <= `DDRB2_RST_BIT;
    end else begin
      lat_ff[0] <= (state_ff == ddrb2_pkg::OP_READ);
    end
  end

  // Pair data rides beside the latency flag.
  always_ff @(posedge i_clock) begin
    pipe_ff[0] <= fetch;
  end

  // Further latency stages.
  generate
    for (genvar s = 1; s < RD_LAT; s++) begin : g_lat
      always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
          lat_ff[s] <= `DDRB2_RST_BIT;
        end else begin
          lat_ff[s] <= lat_ff[s-1];
        end
      end
      always_ff @(posedge i_clock) begin
        pipe_ff[s] <= pipe_ff[s-1];
      end
    end
  endgenerate

  assign start_k = lat_ff[RD_LAT-1];

  // Single-clock launcher runs on the input clock pair.
  ddrb2_launch u_k_launch (
    .i_clk(i_clock),
    .i_nrst(i_nrst),
    .i_start(start_k && mode_k),
    .i_pair(pipe_ff[RD_LAT-1]),
    .o_data(k_data),
    .o_oe(k_oe)
  );

  // Hand-off word and toggle for the output clock domain.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      rd_tgl_ff <= `DDRB2_RST_BIT;
    end else if (start_k && !mode_k) begin
      rd_tgl_ff <= ~rd_tgl_ff;
    end
  end

  // The word stays still while the toggle crosses.
  always_ff @(posedge i_clock) begin
    if (start_k && !mode_k) begin
      xfer_ff <= pipe_ff[RD_LAT-1];
    end
  end

  // Reset and toggle reach the output clock through two flops each.
  ddrb2_sync u_rst_sync (
    .i_clk(i_out_clock),
    .i_d(i_nrst),
    .o_q(nrst_c)
  );

  ddrb2_sync u_tgl_sync (
    .i_clk(i_out_clock),
    .i_d(rd_tgl_ff),
    .o_q(tgl_c)
  );

  // Edge of the crossed toggle starts one output burst.
  always_ff @(posedge i_out_clock) begin
    if (!nrst_c) begin
      tgl_d_ff <= `DDRB2_RST_BIT;
    end else begin
      tgl_d_ff <= tgl_c;
    end
  end

  assign start_c = tgl_c ^ tgl_d_ff;

  // Dual-clock launcher runs on the output data clock pair.
  ddrb2_launch u_c_launch (
    .i_clk(i_out_clock),
    .i_nrst(nrst_c),
    .i_start(start_c),
    .i_pair(xfer_ff),
    .o_data(c_data),
    .o_oe(c_oe)
  );

  // Pick the active launcher; drivers are off with no read.
  assign o_dq_o = mode_k ? k_data : c_data;
  assign o_dq_oe = mode_k ? k_oe : c_oe;

  // Echo clocks follow whichever clock launches data.
  assign o_echo_clk = mode_k ? i_clock : i_out_clock;
  assign o_echo_clk_n = ~o_echo_clk;

  // A read load followed by its decode.
  sequence s_read_load;
    cmd_sel && i_rnw;
  endsequence

  sequence s_read_state;
    state_ff == ddrb2_pkg::OP_READ;
  endsequence

  property p_read_decode;
    @(posedge i_clock) disable iff (!i_nrst)
      s_read_load |=> s_read_state;
  endproperty

  property p_k_latency;
    @(posedge i_clock) disable iff (!i_nrst)
      s_read_state ##0 mode_k ##LAUNCH_DLY mode_k
        |-> k_oe;
  endproperty

  a_read_decode: assert property (p_read_decode)
    else $error("read load not decoded as read");

  a_write_decode: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
      cmd_sel && !i_rnw |=> state_ff == ddrb2_pkg::OP_WRITE)
    else $error("write load not decoded as write");

  a_deselect_idle: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
      !cmd_sel |=> state_ff == ddrb2_pkg::OP_IDLE)
    else $error("deselected cycle started an access");

  a_addr_held: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
      !cmd_sel |=> $stable(req_ff))
    else $error("address changed while deselected");

  a_k_read_launch: assert property (p_k_latency)
    else $error("single-clock read not driven after latency");

  a_oe_cause: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
      k_oe |-> $past(state_ff, LAUNCH_DLY) == ddrb2_pkg::OP_READ)
    else $error("drivers enabled without a read");

  a_seed_word: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
      state_ff == ddrb2_pkg::OP_WRITE && !req_ff.lsb |=>
        arr0_ff[$past(row)] ==
          lane_merge($past(arr0_ff[row]), $past(beat0_ff)))
    else $error("first beat not merged at seed address");

  a_next_word: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
      state_ff == ddrb2_pkg::OP_WRITE && !req_ff.lsb |=>
        arr1_ff[$past(row)] ==
          lane_merge($past(arr1_ff[row]), $past(beat1_ff)))
    else $error("second beat not merged at next address");

  a_c_burst: assert property (
    @(posedge i_out_clock) disable iff (!nrst_c)
      start_c |=> c_oe ##1 !c_oe)
    else $error("output clock burst not one cycle long");

  a_dual_quiet: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
      !mode_k && !$past(mode_k) |-> ##1 !k_oe)
    else $error("input clock launcher active in dual mode");

endmodule

`default_nettype wire

// >>> sim/ddrb2_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "ddrb2_params.svh"

// Behavioural memory controller that drives the command and write pins.
module ddrb2_ctrl_model (
  // Input clock of the port.
  input wire logic i_clock,
  // Command and write pins towards the port.
  output logic o_load_strobe_n,
  output logic o_rnw,
  output logic [`DDRB2_ADDR_W-2:0] o_addr,
  output logic o_lsb,
  output logic [`DDRB2_LANES-1:0] o_byte_write_sel_n,
  output logic [`DDRB2_DATA_W-1:0] o_dq
);
  // Pins start idle at known levels.
  initial begin
    o_load_strobe_n = 1'h1;
    o_rnw = 1'h0;
    o_addr = '0;
    o_lsb = 1'h0;
    o_byte_write_sel_n = '1;
    o_dq = '0;
  end

  // Released pins flip, so a port that samples them while idle misbehaves.
  task automatic release_pins();
    o_load_strobe_n = 1'h1;
    o_rnw = ~o_rnw;
    o_addr = ~o_addr;
    o_lsb = ~o_lsb;
    o_byte_write_sel_n = ~o_byte_write_sel_n;
    o_dq = ~o_dq;
  endtask

  // Loads a command; reads and writes share the address pins.
  task automatic load(input logic rnw, input logic [`DDRB2_ADDR_W-2:0] row,
                      input logic lsb);
    @(posedge i_clock);
    #2;
    o_load_strobe_n = 1'h0;
    o_rnw = rnw;
    o_addr = row;
    o_lsb = lsb;
  endtask

  // Write burst: beat 0 rides with the load, beat 1 follows at mid-cycle.
  task automatic write_burst(input logic [`DDRB2_ADDR_W-2:0] row,
                             input logic lsb,
                             input logic [`DDRB2_DATA_W-1:0] d0, d1,
                             input logic [`DDRB2_LANES-1:0] m0, m1);
    load(1'h0, row, lsb);
    o_dq = d0;
    o_byte_write_sel_n = m0;
    @(posedge i_clock);
    #2;
    o_load_strobe_n = 1'h1;
    o_addr = ~o_addr;
    o_dq = d1;
    o_byte_write_sel_n = m1;
    @(posedge i_clock);
    #2;
    release_pins();
  endtask

  // Read command; the two returned words form one burst.
  task automatic read_burst(input logic [`DDRB2_ADDR_W-2:0] row,
                            input logic lsb);
    load(1'h1, row, lsb);
    @(posedge i_clock);
    #2;
    release_pins();
  endtask
endmodule
`default_nettype wire

// >>> sim/ddrb2_port_tb.sv
`timescale 1ns/1ns
`default_nettype none

// Self-checking bench for the burst SRAM port.
module ddrb2_port_tb;
  localparam int AAW = 4;
  localparam int RDL = 1;
  logic i_clock = 1'h0;
  logic i_out_clock = 1'h0;
  logic i_nrst = 1'h0;
  logic i_single_clk_mode = 1'h1;
  logic load_n, rnw, lsb, dq_oe, echo, echo_n;
  logic [18:0] addr;
  logic [1:0] byte_sel_n;
  logic [17:0] ctl_dq, dq_o, dq_bus;
  logic [17:0] exp_mem [16][2];
  int n_fail = 0;
  int n_compared = 0;

  // Input clock at 40 ns; output clock at 64 ns with its own phase.
  always #20 i_clock = ~i_clock;
  initial begin
    #5;
    forever #32 i_out_clock = ~i_out_clock;
  end

  // The port's drivers win the shared bus while enabled.
  assign dq_bus = (dq_oe === 1'h1) ? dq_o : ctl_dq;

  ddrb2_ctrl_model ctl (.i_clock(i_clock), .o_load_strobe_n(load_n),
    .o_rnw(rnw), .o_addr(addr), .o_lsb(lsb),
    .o_byte_write_sel_n(byte_sel_n), .o_dq(ctl_dq));

  ddrb2_port #(.ARRAY_AW(AAW), .RD_LAT(RDL)) uut (.i_clock(i_clock),
    .i_nrst(i_nrst), .i_out_clock(i_out_clock),
    .i_single_clk_mode(i_single_clk_mode), .i_load_strobe_n(load_n),
    .i_rnw(rnw), .i_addr(addr), .i_burst_lsb_addr(lsb),
    .i_byte_write_sel_n(byte_sel_n), .i_dq_i(dq_bus), .o_dq_o(dq_o),
    .o_dq_oe(dq_oe), .o_echo_clk(echo), .o_echo_clk_n(echo_n));

  // Prints the verdict and stops.
  task automatic complete_run();
    if (n_fail == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Compares one flag.
  task automatic cmp_bit(input logic got, input logic exp, input string s);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %b exp %b", $time, s, got, exp);
    end
  endtask

  // Compares one data word.
  task automatic cmp_word(input logic [17:0] got, input logic [17:0] exp,
                          input string s);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  // Lane merge of the expected store; a low select writes its lane.
  function automatic logic [17:0] merge(logic [17:0] o, logic [17:0] n,
                                        logic [1:0] m);
    merge = o;
    if (!m[0]) merge[8:0] = n[8:0];
    if (!m[1]) merge[17:9] = n[17:9];
  endfunction

  // Waits for an edge of the clock that launches read data, then settles.
  task automatic wait_edge(input logic pos);
    if (i_single_clk_mode === 1'h1) begin
      if (pos) @(posedge i_clock); else @(negedge i_clock);
    end else begin
      if (pos) @(posedge i_out_clock); else @(negedge i_out_clock);
    end
    #5;
  endtask

  // Writes a burst and updates the expected store.
  task automatic do_write(input logic [3:0] r, input logic b,
                          input logic [17:0] d0, d1, input logic [1:0] m0, m1);
    exp_mem[r][b] = merge(exp_mem[r][b], d0, m0);
    exp_mem[r][~b] = merge(exp_mem[r][~b], d1, m1);
    ctl.write_burst({15'h0, r}, b, d0, d1, m0, m1);
  endtask

  // Reads a burst and checks word order and release; timing only in single-clock mode.
  task automatic do_read(input logic [3:0] r, input logic b);
    logic [17:0] w0;
    logic [17:0] w1;
    w0 = exp_mem[r][b];
    w1 = exp_mem[r][~b];
    ctl.read_burst({15'h0, r}, b);
    if (i_single_clk_mode === 1'h1) begin
      for (int i = 0; i < RDL; i++) begin
        wait_edge(1'h1);
        cmp_bit(dq_oe, 1'h0, "early drive");
      end
      wait_edge(1'h1);
    end else begin
      for (int i = 0; i < 16 && dq_oe !== 1'h1; i++) wait_edge(1'h1);
    end
    cmp_bit(dq_oe, 1'h1, "drive on");
    cmp_word(dq_o, w0, "first word");
    wait_edge(1'h0);
    cmp_word(dq_o, w1, "second word");
    wait_edge(1'h1);
    cmp_bit(dq_oe, 1'h0, "drive off");
  endtask

  // Echo clocks follow the launch clock.
  task automatic check_echo();
    wait_edge(1'h1);
    cmp_bit(echo, 1'h1, "echo high");
    cmp_bit(echo_n, 1'h0, "echo inverse");
    wait_edge(1'h0);
    cmp_bit(echo, 1'h0, "echo low");
  endtask

  // Seed order and shared address pins in single-clock mode.
  task automatic t_order();
    do_write(4'h3, 1'h0, 18'h1A5A5, 18'h2C3C3, 2'h0, 2'h0);
    do_write(4'h5, 1'h1, 18'h0F0F0, 18'h30303, 2'h0, 2'h0);
    do_read(4'h3, 1'h0);
    do_read(4'h3, 1'h1);
    do_read(4'h5, 1'h0);
  endtask

  // Every lane-select pattern, opposite patterns on the two beats.
  task automatic t_masks();
    do_write(4'h7, 1'h0, 18'h15555, 18'h2AAAA, 2'h0, 2'h0);
    for (int m = 0; m < 4; m++) begin
      do_write(4'h7, m[0], 18'h12340 + m, 18'h0BCD0 ^ m, m[1:0],
               ~m[1:0]);
      do_read(4'h7, 1'h0);
    end
  endtask

  // Reads launched on the output clock pair.
  task automatic t_dual();
    do_read(4'h3, 1'h0);
    repeat (4) @(posedge i_clock);
    // Fill the row first so the masked lane below has a known old value.
    do_write(4'h9, 1'h1, 18'h11111, 18'h22222, 2'h0, 2'h0);
    do_write(4'h9, 1'h1, 18'h3C0F1, 18'h03F0E, 2'h1, 2'h0);
    do_read(4'h9, 1'h0);
  endtask

  // Main sequence.
  initial begin
    repeat (6) @(posedge i_clock);
    #2;
    cmp_bit(dq_oe, 1'h0, "drive in reset");
    i_nrst = 1'h1;
    check_echo();
    t_order();
    t_masks();
    @(posedge i_clock);
    #2;
    i_single_clk_mode = 1'h0;
    repeat (10) @(posedge i_clock);
    check_echo();
    t_dual();
    complete_run();
  end

  // Watchdog against a hang.
  initial begin
    #100000;
    n_fail++;
    complete_run();
  end
endmodule
`default_nettype wire
